// ---- debug_mode_control_test.sv ----
`timescale 1ns/1ps

module debug_mode_control_test;
   logic mclk, link_clk, reset_n, brk_exec, retd_exec, brk_req, link_tx_data, link_tx_oe, lvl;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0] wstrb, brk_len, clk_edges, e0, strb;
   logic [1:0] bresp, rresp, rs;
   logic [2:0] port_out, port_oe, sel;
   logic debug_mode, dbg_irq, irq_block, nmi_block, dbg_clock_out, dbg_clock_out_oe, dbg_status_out;
   logic dbg_status_out_oe, dbg_data_io_in, dbg_data_io_out, dbg_data_io_oe, port_data_in, link_rx_data;
   dmc_pkg::dmc_run_type run_en;
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;

   dmc_debug_mode_control dmc_debug_mode_control_inst (
      .mclk(mclk), .reset_n(reset_n), .link_clk(link_clk), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .brk_exec(brk_exec), .retd_exec(retd_exec), .debug_mode(debug_mode), .dbg_irq(dbg_irq),
      .irq_block(irq_block), .nmi_block(nmi_block), .run_en(run_en), .dbg_clock_out(dbg_clock_out),
      .dbg_clock_out_oe(dbg_clock_out_oe), .dbg_status_out(dbg_status_out),
      .dbg_status_out_oe(dbg_status_out_oe), .dbg_data_io_in(dbg_data_io_in),
      .dbg_data_io_out(dbg_data_io_out), .dbg_data_io_oe(dbg_data_io_oe), .port_out(port_out),
      .port_oe(port_oe), .port_data_in(port_data_in), .link_tx_data(link_tx_data),
      .link_tx_oe(link_tx_oe), .link_rx_data(link_rx_data));

   dmc_probe_model dmc_probe_model_inst (
      .link_clk(link_clk), .reset_n(reset_n), .probe_clk(dbg_clock_out), .brk_req(brk_req),
      .brk_len(brk_len), .pin_out(dbg_data_io_out), .pin_oe(dbg_data_io_oe), .pin_level(dbg_data_io_in),
      .clk_edges(clk_edges));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   initial begin
      link_clk = 1'b0;
      #7;
      forever #15 link_clk = ~link_clk;
   end

   // ----------------------------------------------------------------
   // Compare, bus and event tasks
   // ----------------------------------------------------------------
   task automatic check_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task finish_test();
      if (failures == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge mclk);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= strb; bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge mclk);
         if (awvalid && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
         if (wvalid && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
      end
      do @(posedge mclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic check_reg(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] resp);
      @(posedge mclk);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      do @(posedge mclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge mclk); while (!rvalid);
      rready <= 1'b0;
      check_word(rdata, exp);
      check_word({30'h0, rresp}, {30'h0, resp});
   endtask

   task automatic core_pulse(input logic brk);
      @(posedge mclk);
      if (brk) brk_exec <= 1'b1;
      else retd_exec <= 1'b1;
      @(posedge mclk);
      brk_exec <= 1'b0; retd_exec <= 1'b0;
      #1;
   endtask

   function automatic logic [3:0] exp_run(input logic dbg, input logic psc, input logic ls);
      return dbg ? {psc, ls, 2'b11} : 4'hf;
   endfunction

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(87915));
      reset_n = 1'b0; brk_exec = 1'b0; retd_exec = 1'b0; brk_req = 1'b0; brk_len = 4'h4;
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      awaddr = 32'h0; wdata = 32'h0; wstrb = 4'h0; araddr = 32'h0;
      strb = 4'hf;
      port_out = 3'h0; port_oe = 3'h0; link_tx_data = 1'b0; link_tx_oe = 1'b0;
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      #1;
      check_word({28'h0, run_en}, 32'hf);
      check_word({29'h0, dbg_clock_out_oe, dbg_status_out_oe, dbg_data_io_oe}, 32'h6);
      check_reg(dmc_pkg::ADDR_LOWSPEED_CTRL, 32'h0, dmc_pkg::RESP_OKAY);
      check_reg(dmc_pkg::ADDR_PORT3_SEL, 32'h0, dmc_pkg::RESP_OKAY);
      check_reg(dmc_pkg::ADDR_PSC_CTRL, 32'h0, dmc_pkg::RESP_OKAY);
      check_reg(dmc_pkg::ADDR_DBG_STATUS, 32'h0, dmc_pkg::RESP_OKAY);
      check_reg(dmc_pkg::ADDR_RAM_BASE, 32'h0000_0fc0, dmc_pkg::RESP_OKAY);
      // Unmapped place, clear of the debug work area
      check_reg(32'h0000_0100, 32'h0, dmc_pkg::RESP_SLVERR);
      axi_write(dmc_pkg::ADDR_RAM_BASE, 32'hffff_ffff, rs);
      check_word({30'h0, rs}, {30'h0, dmc_pkg::RESP_OKAY});
      check_reg(dmc_pkg::ADDR_RAM_BASE, 32'h0000_0fc0, dmc_pkg::RESP_OKAY);
      // Reserved bits always written as zero
      axi_write(dmc_pkg::ADDR_LOWSPEED_CTRL, 32'h0000_0001, rs);
      check_reg(dmc_pkg::ADDR_LOWSPEED_CTRL, 32'h1, dmc_pkg::RESP_OKAY);
      // Write without byte lane zero leaves the run bit alone
      strb = 4'he;
      axi_write(dmc_pkg::ADDR_LOWSPEED_CTRL, 32'h0, rs);
      strb = 4'hf;
      check_word({30'h0, rs}, {30'h0, dmc_pkg::RESP_OKAY});
      check_reg(dmc_pkg::ADDR_LOWSPEED_CTRL, 32'h1, dmc_pkg::RESP_OKAY);
      axi_write(32'h0000_0100, 32'h0, rs);
      check_word({30'h0, rs}, {30'h0, dmc_pkg::RESP_SLVERR});
      // Entry and exit for every run-bit combination
      for (int k = 0; k < 4; k++) begin
         axi_write(dmc_pkg::ADDR_PSC_CTRL, {30'h0, k[1], 1'b0}, rs);
         axi_write(dmc_pkg::ADDR_LOWSPEED_CTRL, {31'h0, k[0]}, rs);
         core_pulse(1'b0);
         check_bit(debug_mode, 1'b0);
         core_pulse(1'b1);
         check_word({29'h0, debug_mode, dbg_irq, irq_block}, 32'h7);
         check_bit(nmi_block, 1'b1);
         check_word({28'h0, run_en}, {28'h0, exp_run(1'b1, k[1], k[0])});
         @(posedge mclk);
         #1;
         check_bit(dbg_irq, 1'b0);
         check_reg(dmc_pkg::ADDR_DBG_STATUS, 32'h1, dmc_pkg::RESP_OKAY);
         core_pulse(1'b1);
         check_word({30'h0, debug_mode, dbg_irq}, 32'h2);
         core_pulse(1'b0);
         check_word({29'h0, debug_mode, irq_block, nmi_block}, 32'h0);
         check_word({28'h0, run_en}, 32'hf);
      end
      // Pin function select with random port and link traffic
      for (int i = 0; i < 8; i++) begin
         // Line released first, so a pin handover never looks like a probe break
         @(posedge link_clk);
         link_tx_oe <= 1'b0;
         repeat (2) @(posedge link_clk);
         sel = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($urandom);
         axi_write(dmc_pkg::ADDR_PORT3_SEL, {28'h0, sel, 1'b0}, rs);
         @(posedge mclk);
         port_out <= 3'($urandom); port_oe <= 3'($urandom);
         @(posedge link_clk);
         link_tx_data <= 1'($urandom); link_tx_oe <= 1'($urandom);
         e0 = clk_edges;
         repeat (6) @(posedge link_clk);
         #1;
         if (sel[0]) check_word({30'h0, dbg_clock_out_oe, dbg_clock_out}, {30'h0, port_oe[0], port_out[0]});
         else check_bit(dbg_clock_out_oe && clk_edges != e0, 1'b1);
         check_word({30'h0, dbg_status_out_oe, dbg_status_out}, {30'h0, sel[1] ? {port_oe[1], port_out[1]} : 2'b10});
         check_bit(dbg_data_io_oe, sel[2] ? port_oe[2] : link_tx_oe);
         lvl = (sel[2] ? port_oe[2] : link_tx_oe) ? (sel[2] ? port_out[2] : link_tx_data) : 1'b1;
         check_bit(port_data_in, lvl);
         if (!sel[2]) check_bit(link_rx_data, lvl);
      end
      // Probe break: refused on a port pin, taken in debug use
      @(posedge link_clk);
      link_tx_oe <= 1'b0;
      for (int j = 0; j < 2; j++) begin
         axi_write(dmc_pkg::ADDR_PORT3_SEL, j ? 32'h0 : 32'h8, rs);
         @(posedge mclk);
         port_oe <= 3'h0; brk_len <= 4'(4 + $urandom % 6); brk_req <= 1'b1;
         repeat (2) @(posedge link_clk);
         @(posedge mclk);
         brk_req <= 1'b0;
         for (int n = 0; n < 40 && !debug_mode; n++) @(posedge mclk);
         #1;
         check_bit(debug_mode, 1'(j));
         repeat (20) @(posedge link_clk);
         #1;
         if (j) check_bit(dbg_status_out, 1'b1);
         core_pulse(1'b0);
         check_bit(debug_mode, 1'b0);
      end
      finish_test();
   end
endmodule

// ---- dmc_debug_mode_control.sv ----
`timescale 1ns/1ps

// What this block does
// - Read-only base register reads 0xfc0, upper byte always zero.
// - After reset the three shared pins serve the debug link.
// - Select bits 1, 2, 3 hand clock, status, data pins to the port.
// - Debug use drives clock, status and bidirectional data with break input.
// - Break instruction or probe pulling data low enters debug mode with interrupt.
// - Only the return-from-debug instruction leaves debug mode.
// - No hardware interrupt or NMI accepted while in debug mode.
// - Prescaler halts in debug mode unless its debug-run bit is set.
// - Prescaler-clocked peripherals halt whenever the prescaler halts.
// - Low-speed clock, watchdog, stopwatch timers stop in debug mode unless low-speed run bit set.
// - Low-speed 8-bit timer never stops for debug mode.
// - LCD driver keeps running through debug mode.
// - Reserved bits written zero; low-speed control bits 7 to 1 read zero.
module dmc_debug_mode_control (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic link_clk,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic brk_exec,
   input wire logic retd_exec,
   output logic debug_mode,
   output logic dbg_irq,
   output logic irq_block,
   output logic nmi_block,
   output dmc_pkg::dmc_run_type run_en,
   output logic dbg_clock_out,
   output logic dbg_clock_out_oe,
   output logic dbg_status_out,
   output logic dbg_status_out_oe,
   input wire logic dbg_data_io_in,
   output logic dbg_data_io_out,
   output logic dbg_data_io_oe,
   input wire logic [2:0] port_out,
   input wire logic [2:0] port_oe,
   output logic port_data_in,
   input wire logic link_tx_data,
   input wire logic link_tx_oe,
   output logic link_rx_data
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [31:0] addr, input logic [31:0] base);
      hit = (addr[31:2] == base[31:2]);
   endfunction

   function automatic logic mapped(input logic [31:0] addr);
      mapped = hit(addr, dmc_pkg::ADDR_LOWSPEED_CTRL) || hit(addr, dmc_pkg::ADDR_PORT3_SEL)
         || hit(addr, dmc_pkg::ADDR_PSC_CTRL) || hit(addr, dmc_pkg::ADDR_RAM_BASE)
         || hit(addr, dmc_pkg::ADDR_DBG_STATUS);
   endfunction

   dmc_pkg::dmc_core_state_type st_r;
   dmc_pkg::dmc_core_state_type st_nxt;
   dmc_pkg::dmc_link_state_type ln_r;
   dmc_pkg::dmc_link_state_type ln_nxt;
   logic brk_evt;
   logic enter;
   logic leave;
   logic [31:0] rd_val;

   // ----------------------------------------------------------------
   // Bus handshakes
   // ----------------------------------------------------------------
   assign awready = !st_r.aw_got;
   assign wready = !st_r.w_got;
   assign arready = !st_r.rvalid;
   assign bvalid = st_r.bvalid;
   assign bresp = st_r.bresp;
   assign rvalid = st_r.rvalid;
   assign rdata = st_r.rdata;
   assign rresp = st_r.rresp;

   // Probe break: toggle compared at second and third stage
   assign brk_evt = st_r.brk_sync[2] ^ st_r.brk_sync[1];
   assign enter = (brk_exec || brk_evt) && (st_r.mode == dmc_pkg::DMC_RUN);
   assign leave = retd_exec && (st_r.mode == dmc_pkg::DMC_DEBUG);

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always_comb begin
      rd_val = 32'h0000_0000;
      if (hit(araddr, dmc_pkg::ADDR_LOWSPEED_CTRL)) begin
         rd_val[dmc_pkg::LS_RUN_BIT] = st_r.ls_run;
      end else if (hit(araddr, dmc_pkg::ADDR_PORT3_SEL)) begin
         rd_val[dmc_pkg::SEL_DATA_BIT:dmc_pkg::SEL_CLK_BIT] = st_r.pin_sel;
      end else if (hit(araddr, dmc_pkg::ADDR_PSC_CTRL)) begin
         rd_val[dmc_pkg::PSC_RUN_BIT] = st_r.psc_run;
      end else if (hit(araddr, dmc_pkg::ADDR_RAM_BASE)) begin
         rd_val = dmc_pkg::DBG_RAM_BASE;
      end else if (hit(araddr, dmc_pkg::ADDR_DBG_STATUS)) begin
         rd_val[dmc_pkg::STATUS_MODE_BIT] = (st_r.mode == dmc_pkg::DMC_DEBUG);
      end
   end

   // ----------------------------------------------------------------
   // System clock domain
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.dbg_irq = enter;
      st_nxt.brk_sync = {st_r.brk_sync[1:0], ln_r.brk_tgl};
      if (leave) begin
         st_nxt.mode = dmc_pkg::DMC_RUN;
      end else if (enter) begin
         st_nxt.mode = dmc_pkg::DMC_DEBUG;
      end
      if (awvalid && awready) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         st_nxt.w_got = 1'b1;
         st_nxt.w_data = wdata;
         st_nxt.w_strb = wstrb;
      end
      if (st_r.bvalid && bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = mapped(st_r.aw_addr) ? dmc_pkg::RESP_OKAY : dmc_pkg::RESP_SLVERR;
         if (st_r.w_strb[0]) begin
            if (hit(st_r.aw_addr, dmc_pkg::ADDR_LOWSPEED_CTRL)) begin
               st_nxt.ls_run = st_r.w_data[dmc_pkg::LS_RUN_BIT];
            end
            if (hit(st_r.aw_addr, dmc_pkg::ADDR_PORT3_SEL)) begin
               st_nxt.pin_sel = st_r.w_data[dmc_pkg::SEL_DATA_BIT:dmc_pkg::SEL_CLK_BIT];
            end
            if (hit(st_r.aw_addr, dmc_pkg::ADDR_PSC_CTRL)) begin
               st_nxt.psc_run = st_r.w_data[dmc_pkg::PSC_RUN_BIT];
            end
         end
      end
      if (st_r.rvalid && rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = rd_val;
         st_nxt.rresp = mapped(araddr) ? dmc_pkg::RESP_OKAY : dmc_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.ls_run <= dmc_pkg::RST_LS_RUN;
         st_r.psc_run <= dmc_pkg::RST_PSC_RUN;
         st_r.pin_sel <= dmc_pkg::RST_PIN_SEL;
         st_r.mode <= dmc_pkg::DMC_RUN;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Core and peripheral gating outputs
   // ----------------------------------------------------------------
   assign debug_mode = (st_r.mode == dmc_pkg::DMC_DEBUG);
   assign dbg_irq = st_r.dbg_irq;
   assign irq_block = debug_mode;
   assign nmi_block = debug_mode;
   // Gates only; held peripheral state continues on release
   assign run_en.prescaler = !debug_mode || st_r.psc_run;
   assign run_en.lowspeed = !debug_mode || st_r.ls_run;
   assign run_en.lowspeed_t8 = 1'b1;
   assign run_en.lcd = 1'b1;

   // ----------------------------------------------------------------
   // Link clock domain
   // ----------------------------------------------------------------
   always_comb begin
      ln_nxt = ln_r;
      ln_nxt.data_sync = {ln_r.data_sync[1:0], dbg_data_io_in};
      if (ln_r.data_sync[1] == ln_r.data_sync[2]) begin
         ln_nxt.data_filt = ln_r.data_sync[2];
      end
      // Falling data line from the probe while pin is in debug use
      if (ln_r.data_filt && !ln_nxt.data_filt && !ln_r.sel_sync[1] && !ln_r.tx_oe) begin
         ln_nxt.brk_tgl = !ln_r.brk_tgl;
      end
      ln_nxt.mode_sync = {ln_r.mode_sync[0], debug_mode};
      ln_nxt.sel_sync = {ln_r.sel_sync[0], st_r.pin_sel[2]};
      ln_nxt.clk_div = !ln_r.clk_div;
      ln_nxt.status = ln_r.mode_sync[1];
      ln_nxt.tx_data = link_tx_data;
      ln_nxt.tx_oe = link_tx_oe;
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         ln_r <= '0;
         ln_r.data_sync <= 3'h7;
         ln_r.data_filt <= 1'b1;
      end else begin
         ln_r <= ln_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Shared pin multiplexing
   // ----------------------------------------------------------------
   assign dbg_clock_out = st_r.pin_sel[0] ? port_out[0] : ln_r.clk_div;
   assign dbg_clock_out_oe = st_r.pin_sel[0] ? port_oe[0] : 1'b1;
   assign dbg_status_out = st_r.pin_sel[1] ? port_out[1] : ln_r.status;
   assign dbg_status_out_oe = st_r.pin_sel[1] ? port_oe[1] : 1'b1;
   assign dbg_data_io_out = st_r.pin_sel[2] ? port_out[2] : ln_r.tx_data;
   assign dbg_data_io_oe = st_r.pin_sel[2] ? port_oe[2] : ln_r.tx_oe;
   assign port_data_in = dbg_data_io_in;
   assign link_rx_data = ln_r.data_filt;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   a_base_read_value:
      assert property (arvalid && arready && hit(araddr, dmc_pkg::ADDR_RAM_BASE)
         |=> rvalid && rdata == 32'h0000_0fc0 && rresp == dmc_pkg::RESP_OKAY)
      else $error("debug ram base read wrong");

   a_lowspeed_reserved_zero:
      assert property (arvalid && arready && hit(araddr, dmc_pkg::ADDR_LOWSPEED_CTRL)
         |=> rdata[31:1] == 31'h0000_0000)
      else $error("reserved low-speed bits not zero");

   a_pin_select_write:
      assert property (st_r.aw_got && st_r.w_got && !st_r.bvalid && st_r.w_strb[0]
         && hit(st_r.aw_addr, dmc_pkg::ADDR_PORT3_SEL)
         |=> st_r.pin_sel == $past(st_r.w_data[3:1]) && bvalid)
      else $error("pin select not updated");

   a_debug_pins_default:
      assert property (!st_r.pin_sel[0] && !st_r.pin_sel[1]
         |-> dbg_clock_out_oe && dbg_status_out_oe && dbg_status_out == ln_r.status)
      else $error("debug pins not in debug use");

   a_break_entry:
      assert property (!debug_mode && brk_exec && !retd_exec |=> debug_mode && dbg_irq ##1 !dbg_irq)
      else $error("break did not enter debug mode");

   a_mode_holds:
      assert property (debug_mode && !retd_exec |=> debug_mode)
      else $error("debug mode left without return");

   a_mode_leaves:
      assert property (debug_mode && retd_exec |=> !debug_mode && !irq_block)
      else $error("return did not leave debug mode");

   a_irq_masked:
      assert property (!debug_mode && brk_exec |=> irq_block && nmi_block)
      else $error("interrupts accepted in debug mode");

   a_prescaler_halt:
      assert property (debug_mode && !st_r.psc_run |-> !run_en.prescaler)
      else $error("prescaler runs in debug mode");

   a_lowspeed_halt:
      assert property (debug_mode |-> run_en.lowspeed == st_r.ls_run && run_en.lowspeed_t8 && run_en.lcd)
      else $error("low-speed gating wrong");

   a_resume_after:
      assert property (debug_mode && retd_exec |=> run_en.prescaler && run_en.lowspeed)
      else $error("peripherals not resumed");

   a_link_clock_runs:
      assert property (@(posedge link_clk) disable iff (!reset_n) ln_r.clk_div |=> !ln_r.clk_div)
      else $error("debug clock divider stuck");

   a_irq_single_pulse:
      assert property (dbg_irq |-> debug_mode ##1 !dbg_irq)
      else $error("debug interrupt not a single pulse");

   a_probe_break_entry:
      assert property (!debug_mode && brk_evt |=> debug_mode && dbg_irq)
      else $error("probe break did not enter debug mode");

   a_status_register:
      assert property (arvalid && arready && hit(araddr, dmc_pkg::ADDR_DBG_STATUS)
         |=> rdata == {31'h0000_0000, $past(debug_mode)})
      else $error("status register does not show debug mode");

   a_blocks_follow_mode:
      assert property (irq_block == debug_mode && nmi_block == debug_mode)
      else $error("interrupt blocking not tied to debug mode");

   a_prescaler_kept:
      assert property (debug_mode && st_r.psc_run |-> run_en.prescaler)
      else $error("prescaler stopped despite run bit");

   a_run_outside_debug:
      assert property (!debug_mode |-> run_en.prescaler && run_en.lowspeed)
      else $error("peripherals halted outside debug mode");

   a_exempt_always_run:
      assert property (run_en.lowspeed_t8 && run_en.lcd)
      else $error("exempt peripheral stopped");

   a_strobe_guard:
      assert property (st_r.aw_got && st_r.w_got && !st_r.bvalid && !st_r.w_strb[0]
         |=> $stable(st_r.pin_sel) && $stable(st_r.psc_run) && $stable(st_r.ls_run))
      else $error("write without lane zero changed a register");

   a_status_pin_port:
      assert property (st_r.pin_sel[1] |-> dbg_status_out == port_out[1] && dbg_status_out_oe == port_oe[1])
      else $error("status pin not handed to port");

   a_data_pin_owner:
      assert property (dbg_data_io_oe == (st_r.pin_sel[2] ? port_oe[2] : ln_r.tx_oe))
      else $error("data pin enable from wrong owner");

   a_break_refused_port:
      assert property (@(posedge link_clk) disable iff (!reset_n) ln_r.sel_sync[1] |=> $stable(ln_r.brk_tgl))
      else $error("probe break taken on a port pin");

   a_data_filter:
      assert property (@(posedge link_clk) disable iff (!reset_n)
         ln_r.data_sync[1] == ln_r.data_sync[2] |=> ln_r.data_filt == $past(ln_r.data_sync[2]))
      else $error("data pin filter did not follow agreed stages");

   a_status_tracks_mode:
      assert property (@(posedge link_clk) disable iff (!reset_n)
         ln_r.mode_sync[1] |=> ln_r.status)
      else $error("status output lags debug mode");

endmodule

// ---- dmc_pkg.sv ----
package dmc_pkg;

   // ----------------------------------------------------------------
   // Register indices and byte addresses (byte address = index * 4)
   // ----------------------------------------------------------------
   localparam logic [31:0] IDX_LOWSPEED_CTRL = 32'h0000_5322;
   localparam logic [31:0] IDX_PORT3_SEL = 32'h0000_52a3;
   localparam logic [31:0] IDX_PSC_CTRL = 32'h0000_4020;
   localparam logic [31:0] IDX_RAM_BASE = 32'h00ff_ff90;
   localparam logic [31:0] IDX_DBG_STATUS = 32'h0000_5330;
   localparam logic [31:0] ADDR_LOWSPEED_CTRL = IDX_LOWSPEED_CTRL << 2;
   localparam logic [31:0] ADDR_PORT3_SEL = IDX_PORT3_SEL << 2;
   localparam logic [31:0] ADDR_PSC_CTRL = IDX_PSC_CTRL << 2;
   localparam logic [31:0] ADDR_RAM_BASE = IDX_RAM_BASE << 2;
   localparam logic [31:0] ADDR_DBG_STATUS = IDX_DBG_STATUS << 2;

   // ----------------------------------------------------------------
   // Field positions, reset values, constants
   // ----------------------------------------------------------------
   localparam int LS_RUN_BIT = 0;
   localparam int PSC_RUN_BIT = 1;
   localparam int SEL_CLK_BIT = 1;
   localparam int SEL_STAT_BIT = 2;
   localparam int SEL_DATA_BIT = 3;
   localparam int STATUS_MODE_BIT = 0;
   localparam logic RST_LS_RUN = 1'h0;
   localparam logic RST_PSC_RUN = 1'h0;
   localparam logic [2:0] RST_PIN_SEL = 3'h0;
   localparam logic [31:0] DBG_RAM_BASE = 32'h0000_0fc0;
   localparam logic [31:0] DBG_RAM_LAST = 32'h0000_0fff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic {DMC_RUN, DMC_DEBUG} dmc_mode_type;

   typedef struct packed {
      logic prescaler;
      logic lowspeed;
      logic lowspeed_t8;
      logic lcd;
   } dmc_run_type;

   typedef struct packed {
      logic aw_got;
      logic [31:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic ls_run;
      logic psc_run;
      logic [2:0] pin_sel;
      dmc_mode_type mode;
      logic dbg_irq;
      logic [2:0] brk_sync;
   } dmc_core_state_type;

   typedef struct packed {
      logic [2:0] data_sync;
      logic data_filt;
      logic brk_tgl;
      logic [1:0] mode_sync;
      logic [1:0] sel_sync;
      logic clk_div;
      logic status;
      logic tx_data;
      logic tx_oe;
   } dmc_link_state_type;

endpackage

// ---- dmc_probe_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Debug probe on the shared pins
// ----------------------------------------------------------------
module dmc_probe_model (
   input wire logic link_clk,
   input wire logic reset_n,
   input wire logic probe_clk,
   input wire logic brk_req,
   input wire logic [3:0] brk_len,
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic pin_level,
   output logic [3:0] clk_edges
);
   logic [3:0] low_cnt;

   // Break request holds the data line low for brk_len link cycles
   always @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) low_cnt <= 4'h0;
      else if (brk_req && low_cnt == 4'h0) low_cnt <= brk_len;
      else if (low_cnt != 4'h0) low_cnt <= low_cnt - 4'h1;
   end

   // Counts clock edges received from the device
   always @(posedge probe_clk or negedge reset_n) begin
      if (!reset_n) clk_edges <= 4'h0;
      else clk_edges <= clk_edges + 4'h1;
   end

   // Pull-up level when neither side drives
   assign pin_level = pin_oe ? pin_out : (low_cnt != 4'h0 ? 1'b0 : 1'b1);
endmodule
